//--- rtl/pcd_port_regs.sv
// Purpose: configuration and data registers of ports A to D
// Assumes: MCU strobes are one REF_CLK wide and synchronous
// Notes:   read data appears one clock after the read strobe
//
// What this block does
// - mode bit zero general I/O, one address out
// - mode register exists on ports A and B only
// - direction one is output, reset is input
// - product term ored with direction on A-C
// - port D direction has three live bits
// - drive bit one gives open drain
// - drive bit one gives fast slew
// - drive bit map differs per port
// - data in reads the sampled pin levels
// - data out drives pins when output enabled
// - data out reads back the stored value
// - output cell reads flops, write loads them
// - mask bit one blocks MCU load, reset zero
// - input cells feed PLD and read back
// - enable out reads effective driver enables
// - bit index n controls pin n
// - mode, direction, drive reset to zero
// - plain bus cycles at fixed offsets
`timescale 1ns/1ps
module pcd_port_regs
   import pcd_pkg::*;
(
   input  wire logic          REF_CLK,
   input  wire logic          SRST,
   input  wire pcd_mcu_req_t  MCU_REQ,
   output pcd_byte_t          RDATA,
   output logic               RD_VALID,
   input  wire pcd_port4_t    PIN_IN,
   output pcd_port4_t         PIN_OUT,
   output pcd_port4_t         PIN_OE,
   output pcd_port4_t         PIN_FAST_SLEW,
   input  wire pcd_abc_t      PLD_OE,
   input  wire pcd_ab_t       ADDR_OUT,
   input  wire logic [2:0]    PLD_CELL_LOAD,
   input  wire pcd_abc_t      PLD_CELL_D,
   output pcd_abc_t           OUTPUT_CELL_Q,
   input  wire logic [2:0]    INPUT_CELL_LATCH,
   output pcd_abc_t           INPUT_CELL_Q
);
   import pcd_pkg::*;

   pcd_ab_t     mode;
   pcd_ab_t     next_mode;
   pcd_port4_t  dir;
   pcd_port4_t  next_dir;
   pcd_port4_t  drive;
   pcd_port4_t  next_drive;
   pcd_port4_t  dout;
   pcd_port4_t  next_dout;
   pcd_abc_t    ocell;
   pcd_abc_t    next_ocell;
   pcd_abc_t    omask;
   pcd_abc_t    next_omask;
   pcd_abc_t    icell;
   pcd_abc_t    next_icell;
   pcd_byte_t   rdata;
   pcd_byte_t   next_rdata;
   logic        rd_valid;
   logic        next_rd_valid;
   pcd_port4_t  pin_lvl;
   pcd_port4_t  eff_oe;
   logic [3:0]  acc_grp;
   logic [1:0]  acc_port;
   pcd_byte_t   acc_mask;

   // address split: group and port, no other decode needed
   assign acc_grp  = MCU_REQ.addr[5:2];
   assign acc_port = MCU_REQ.addr[1:0];
   assign acc_mask = impl_bits(acc_grp, acc_port);

   // pins cross into REF_CLK before anyone looks at them
   pcd_pin_sync u_sync (
      .clk   (REF_CLK),
      .srst  (SRST),
      .pin   (PIN_IN),
      .level (pin_lvl)
   );

   // one driver per port, bit n of each register steers pin n
   genvar p;
   generate
      for (p = 0; p < NPORT; p++) begin : g_port
         localparam logic [1:0] PI = 2'(p);
         localparam pcd_byte_t IMPL = impl_bits(GRP_DIRECTION, PI);
         localparam pcd_byte_t ODM =
            (p < 2) ? OD_MASK_AB : ((p == 2) ? ALL_BITS : NO_BITS);
         localparam pcd_byte_t SLM =
            (p < 2) ? SLEW_MASK_AB : ((p == 2) ? NO_BITS : PORT_D_BITS);
         pcd_byte_t pt_oe;
         pcd_byte_t md;
         pcd_byte_t ao;
         assign pt_oe = (p < 3) ? PLD_OE[(p < 3) ? p : 0] : NO_BITS;
         assign md = (p < 2) ? mode[(p < 2) ? p : 0] : NO_BITS;
         assign ao = (p < 2) ? ADDR_OUT[(p < 2) ? p : 0] : NO_BITS;
         pcd_port_drv #(
            .IMPL      (IMPL),
            .OD_MASK   (ODM),
            .SLEW_MASK (SLM),
            .USE_PT_OE (p < 3)
         ) u_drv (
            .dir       (dir[p]),
            .dout      (dout[p]),
            .mode      (md),
            .addr_out  (ao),
            .pt_oe     (pt_oe),
            .drive     (drive[p]),
            .eff_oe    (eff_oe[p]),
            .pin_out   (PIN_OUT[p]),
            .pin_oe    (PIN_OE[p]),
            .fast_slew (PIN_FAST_SLEW[p])
         );
      end
   endgenerate

   // config and data-out writes; absent bits never store
   always_comb begin
      next_mode  = mode;
      next_dir   = dir;
      next_drive = drive;
      next_dout  = dout;
      if (MCU_REQ.wr) begin
         case (acc_grp)
            GRP_MODE: begin
               if (acc_port == PIDX_A || acc_port == PIDX_B) begin
                  next_mode[acc_port[0]] = MCU_REQ.wdata;
               end
            end
            GRP_DIRECTION: begin
               next_dir[acc_port] = MCU_REQ.wdata & acc_mask;
            end
            GRP_DRIVE: begin
               next_drive[acc_port] = MCU_REQ.wdata & acc_mask;
            end
            GRP_DATA_OUT: begin
               next_dout[acc_port] = MCU_REQ.wdata & acc_mask;
            end
            default: ;
         endcase
      end
   end

   // everything comes up as input, general I/O, push-pull, slow
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         mode  <= {2{RST_CFG}};
         dir   <= {NPORT{RST_CFG}};
         drive <= {NPORT{RST_CFG}};
         dout  <= {NPORT{RST_CFG}};
      end else begin
         mode  <= next_mode;
         dir   <= next_dir;
         drive <= next_drive;
         dout  <= next_dout;
      end
   end

   // macrocells: PLD load first, MCU write then overrides unmasked bits
   always_comb begin
      next_ocell = ocell;
      next_omask = omask;
      next_icell = icell;
      for (int c = 0; c < 3; c++) begin
         if (PLD_CELL_LOAD[c]) begin
            next_ocell[c] = PLD_CELL_D[c];
         end
         if (MCU_REQ.wr && acc_grp == GRP_OCELL && acc_port == c[1:0]) begin
            next_ocell[c] = (MCU_REQ.wdata & ~omask[c])
                          | (next_ocell[c] & omask[c]);
         end
         if (MCU_REQ.wr && acc_grp == GRP_OMASK && acc_port == c[1:0]) begin
            next_omask[c] = MCU_REQ.wdata;
         end
         // latch uses the filtered level, never a raw pin
         if (INPUT_CELL_LATCH[c]) begin
            next_icell[c] = pin_lvl[c];
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ocell <= {3{RST_CELL}};
         omask <= {3{RST_CELL}};
         icell <= {3{RST_CELL}};
      end else begin
         ocell <= next_ocell;
         omask <= next_omask;
         icell <= next_icell;
      end
   end

   assign OUTPUT_CELL_Q = ocell;
   assign INPUT_CELL_Q  = icell;

   // read mux; unmapped groups and absent bits return zero
   always_comb begin
      next_rdata    = rdata;
      next_rd_valid = MCU_REQ.rd;
      if (MCU_REQ.rd) begin
         case (acc_grp)
            GRP_DATA_IN:   next_rdata = pin_lvl[acc_port];
            GRP_DATA_OUT:  next_rdata = dout[acc_port];
            GRP_DIRECTION: next_rdata = dir[acc_port];
            GRP_DRIVE:     next_rdata = drive[acc_port];
            GRP_MODE:      next_rdata = mode[acc_port[0]];
            GRP_OCELL:     next_rdata = ocell[acc_port[1] ? 2 : acc_port[0]];
            GRP_OMASK:     next_rdata = omask[acc_port[1] ? 2 : acc_port[0]];
            GRP_ICELL:     next_rdata = icell[acc_port[1] ? 2 : acc_port[0]];
            GRP_ENOUT:     next_rdata = eff_oe[acc_port];
            default:       next_rdata = NO_BITS;
         endcase
         next_rdata = next_rdata & acc_mask;
      end
   end

   // registered read port keeps data off a combinational path
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rdata    <= RST_RDATA;
         rd_valid <= 1'b0;
      end else begin
         rdata    <= next_rdata;
         rd_valid <= next_rd_valid;
      end
   end

   assign RDATA    = rdata;
   assign RD_VALID = rd_valid;

   // checks on the register file and the pin drivers
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);

   cfg_reset_a: assert property (disable iff (1'b0)
      SRST |=> (mode == '0 && dir == '0 && drive == '0 && omask == '0))
      else $error("config not zero after reset");

   dir_write_a: assert property (
      MCU_REQ.wr && acc_grp == GRP_DIRECTION && acc_port == PIDX_B
      |=> dir[1] == $past(MCU_REQ.wdata))
      else $error("direction write to port B not stored");

   portd_bits_a: assert property (
      dir[3][7:3] == 5'h00 && drive[3][7:3] == 5'h00
      && PIN_OE[3][7:3] == 5'h00)
      else $error("port D upper bits became live");

   oe_combine_a: assert property (
      eff_oe[0] == (dir[0] | PLD_OE[0]) && eff_oe[3] == dir[3])
      else $error("output enable not direction or product term");

   od_drive_a: assert property (
      ((drive[2] & dout[2] & PIN_OE[2]) == 8'h00)
      && ((drive[0] & 8'hF0 & PIN_OUT[0]) == 8'h00))
      else $error("open drain pin drove high");

   slew_map_a: assert property (
      PIN_FAST_SLEW[0] == (drive[0] & 8'h0F) && PIN_FAST_SLEW[2] == 8'h00)
      else $error("fast slew map wrong");

   mask_block_a: assert property (
      MCU_REQ.wr && acc_grp == GRP_OCELL && acc_port == PIDX_A
      && !PLD_CELL_LOAD[0]
      |=> (ocell[0] & $past(omask[0])) == ($past(ocell[0]) & $past(omask[0]))
       && (ocell[0] & ~$past(omask[0]))
          == ($past(MCU_REQ.wdata) & ~$past(omask[0])))
      else $error("masked output cell was loaded");

   dout_read_a: assert property (
      MCU_REQ.rd && acc_grp == GRP_DATA_OUT && acc_port == PIDX_B
      |=> RD_VALID && RDATA == $past(dout[1]))
      else $error("data out readback wrong");

   din_read_a: assert property (
      MCU_REQ.rd && acc_grp == GRP_DATA_IN && acc_port == PIDX_C
      |=> RDATA == $past(pin_lvl[2]))
      else $error("data in read not the pin level");

   mode_cd_a: assert property (
      MCU_REQ.rd && acc_grp == GRP_MODE && acc_port[1]
      |=> RDATA == 8'h00)
      else $error("mode register visible on port C or D");

   enout_read_a: assert property (
      MCU_REQ.rd && acc_grp == GRP_ENOUT && acc_port == PIDX_A
      |=> RDATA == $past(eff_oe[0]) ##1 !RD_VALID || $past(MCU_REQ.rd))
      else $error("enable out readback wrong");

   wr_dir_c: cover property (
      MCU_REQ.wr && acc_grp == GRP_DIRECTION ##1 PIN_OE != '0);
   masked_c: cover property (
      MCU_REQ.wr && acc_grp == GRP_OCELL && omask[0] != 8'h00);
   rd_enout_c: cover property (
      MCU_REQ.rd && acc_grp == GRP_ENOUT ##1 RDATA != 8'h00);
endmodule : pcd_port_regs

//--- rtl/pcd_pkg.sv
// Purpose: shared constants and types for the port config and data block
// Assumes: four ports A..D, port D has three pins, 8-bit MCU data path
// Notes:   register address is {group[3:0], port[1:0]} on a 6-bit bus
package pcd_pkg;

   localparam int NPORT = 4;

   typedef logic [7:0]             pcd_byte_t;
   typedef logic [NPORT-1:0][7:0]  pcd_port4_t;
   typedef logic [2:0][7:0]        pcd_abc_t;
   typedef logic [1:0][7:0]        pcd_ab_t;

   // one MCU bus cycle, strobes last one clock
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      pcd_byte_t  wdata;
   } pcd_mcu_req_t;

   // port index in the low address bits
   localparam logic [1:0] PIDX_A = 2'h0;
   localparam logic [1:0] PIDX_B = 2'h1;
   localparam logic [1:0] PIDX_C = 2'h2;
   localparam logic [1:0] PIDX_D = 2'h3;

   // register group in the high address bits
   localparam logic [3:0] GRP_DATA_IN   = 4'h0;
   localparam logic [3:0] GRP_DATA_OUT  = 4'h1;
   localparam logic [3:0] GRP_DIRECTION = 4'h2;
   localparam logic [3:0] GRP_DRIVE     = 4'h3;
   localparam logic [3:0] GRP_MODE      = 4'h4;
   localparam logic [3:0] GRP_OCELL     = 4'h5;
   localparam logic [3:0] GRP_OMASK     = 4'h6;
   localparam logic [3:0] GRP_ICELL     = 4'h7;
   localparam logic [3:0] GRP_ENOUT     = 4'h8;

   // values after reset
   localparam pcd_byte_t RST_CFG   = 8'h00;
   localparam pcd_byte_t RST_CELL  = 8'h00;
   localparam pcd_byte_t RST_RDATA = 8'h00;

   // pin feature maps
   localparam pcd_byte_t ALL_BITS    = 8'hFF;
   localparam pcd_byte_t NO_BITS     = 8'h00;
   localparam pcd_byte_t PORT_D_BITS = 8'h07;
   localparam pcd_byte_t OD_MASK_AB  = 8'hF0;
   localparam pcd_byte_t SLEW_MASK_AB = 8'h0F;

   // bits that exist in a given register of a given port
   function automatic pcd_byte_t impl_bits(input logic [3:0] grp,
                                           input logic [1:0] port);
      pcd_byte_t m;
      m = (port == PIDX_D) ? PORT_D_BITS : ALL_BITS;
      case (grp)
         GRP_DATA_IN, GRP_DATA_OUT, GRP_DIRECTION, GRP_DRIVE: ;
         GRP_MODE: begin
            if (port != PIDX_A && port != PIDX_B) m = NO_BITS;
         end
         GRP_OCELL, GRP_OMASK, GRP_ICELL, GRP_ENOUT: begin
            if (port == PIDX_D) m = NO_BITS;
         end
         default: m = NO_BITS;
      endcase
      return m;
   endfunction : impl_bits

endpackage : pcd_pkg

//--- rtl/pcd_pin_sync.sv
// Purpose: three-stage synchroniser for all port pins
// Assumes: pins are asynchronous to REF_CLK
// Notes:   a change is taken once stages two and three agree
`timescale 1ns/1ps
module pcd_pin_sync
   import pcd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire pcd_port4_t  pin,
   output pcd_port4_t       level
);
   logic [31:0] s1;
   logic [31:0] s2;
   logic [31:0] s3;
   logic [31:0] q;
   logic [31:0] next_q;

   // per bit filter: only stages two and three are compared
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_bit
         always_comb begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
         end
      end
   endgenerate

   // plain shift, stage one feeds only stage two
   always_ff @(posedge clk) begin
      if (srst) begin
         s1 <= 32'h0000_0000;
         s2 <= 32'h0000_0000;
         s3 <= 32'h0000_0000;
         q  <= 32'h0000_0000;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end

   assign level = q;
endmodule : pcd_pin_sync

//--- rtl/pcd_port_drv.sv
// Purpose: pin driver control for one port
// Assumes: config registers are already masked to implemented bits
// Notes:   open drain releases the pin for a one, drives low for a zero
`timescale 1ns/1ps
module pcd_port_drv
   import pcd_pkg::*;
#(
   parameter pcd_byte_t IMPL      = 8'hFF,
   parameter pcd_byte_t OD_MASK   = 8'h00,
   parameter pcd_byte_t SLEW_MASK = 8'h00,
   parameter logic      USE_PT_OE = 1'b1
)(
   input  wire pcd_byte_t dir,
   input  wire pcd_byte_t dout,
   input  wire pcd_byte_t mode,
   input  wire pcd_byte_t addr_out,
   input  wire pcd_byte_t pt_oe,
   input  wire pcd_byte_t drive,
   output pcd_byte_t      eff_oe,
   output pcd_byte_t      pin_out,
   output pcd_byte_t      pin_oe,
   output pcd_byte_t      fast_slew
);
   pcd_byte_t src;
   pcd_byte_t od;

   // direction ored with the product term, where the port has one
   assign eff_oe = (dir | (USE_PT_OE ? pt_oe : NO_BITS)) & IMPL;
   // address out replaces the data register on a mode-one pin
   assign src = (mode & addr_out) | (~mode & dout);
   assign od  = drive & OD_MASK;
   // open drain: drive only the low level
   assign pin_oe  = eff_oe & ~(od & src);
   assign pin_out = src & ~od & IMPL;
   assign fast_slew = drive & SLEW_MASK;
endmodule : pcd_port_drv

//--- dv/pcd_pin_model.sv
// Purpose: board side of the port pins, pull-ups and an outside driver
// Assumes: every pin has a pull-up, so a released pin never floats
// Notes:   ext_level stands for the pull-up or whatever drives the pin
`timescale 1ns/1ps
module pcd_pin_model (
   input  wire pcd_pkg::pcd_port4_t pin_out,
   input  wire pcd_pkg::pcd_port4_t pin_oe,
   input  wire pcd_pkg::pcd_port4_t ext_level,
   output pcd_pkg::pcd_port4_t      pin_level
);
   import pcd_pkg::*;

   // a driven pin shows the block's value, a released one the board's
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         pin_level[p] = (pin_out[p] & pin_oe[p]) | (ext_level[p] & ~pin_oe[p]);
      end
   end
endmodule : pcd_pin_model

//--- dv/tb_port_config_data_regs.sv
// Purpose: self-checking bench for the port config and data registers
// Assumes: one-cycle strobes, read data one clock after the read strobe
// Notes:   pins only reach data in after the synchroniser, so we wait
`timescale 1ns/1ps
module tb_port_config_data_regs;
   import pcd_pkg::*;

   logic         ref_clk;
   logic         srst;
   pcd_mcu_req_t req;
   pcd_byte_t    rdata;
   logic         rd_valid;
   pcd_port4_t   pin_in, pin_out, pin_oe, fast_slew, ext;
   pcd_abc_t     pld_oe, cell_d, ocell_q, icell_q;
   pcd_ab_t      addr_out;
   logic [2:0]   cell_load, icell_latch;
   int           fail_count, samples_checked, cycles;
   logic [3:0]   gl[5] = '{GRP_DATA_OUT, GRP_DIRECTION, GRP_DRIVE,
                           GRP_MODE, GRP_OMASK};

   pcd_port_regs i_pcd_port_regs (
      .REF_CLK(ref_clk), .SRST(srst), .MCU_REQ(req), .RDATA(rdata),
      .RD_VALID(rd_valid), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE(pin_oe), .PIN_FAST_SLEW(fast_slew), .PLD_OE(pld_oe),
      .ADDR_OUT(addr_out), .PLD_CELL_LOAD(cell_load),
      .PLD_CELL_D(cell_d), .OUTPUT_CELL_Q(ocell_q),
      .INPUT_CELL_LATCH(icell_latch), .INPUT_CELL_Q(icell_q));

   pcd_pin_model i_pcd_pin_model (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
      .pin_level(pin_in));

   // 250 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic wrap_up;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic chk(input string name, input pcd_byte_t seen,
                      input pcd_byte_t exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // one write cycle, strobe held exactly one clock
   task automatic wr(input logic [3:0] g, input logic [1:0] p,
                     input pcd_byte_t d);
      @(posedge ref_clk);
      req.wr    <= 1'b1;
      req.addr  <= {g, p};
      req.wdata <= d;
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask : wr

   // one read cycle, answer taken the clock after the strobe
   task automatic rd_chk(input string name, input logic [3:0] g,
                         input logic [1:0] p, input pcd_byte_t exp);
      @(posedge ref_clk);
      req.rd   <= 1'b1;
      req.addr <= {g, p};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      @(posedge ref_clk);
      chk({name, " valid"}, {7'h00, rd_valid}, 8'h01);
      chk(name, rdata, exp);
   endtask : rd_chk

   // bits that exist per group and port
   function automatic pcd_byte_t live(input logic [3:0] g,
                                      input logic [1:0] p);
      if (p == PIDX_D) return (g <= GRP_DRIVE) ? 8'h07 : 8'h00;
      if (g == GRP_MODE && p == PIDX_C) return 8'h00;
      return 8'hFF;
   endfunction : live

   initial begin
      srst = 1'b1;
      req = '0;
      ext = {4{8'hFF}};
      pld_oe = '0;
      cell_d = '0;
      addr_out = '0;
      cell_load = '0;
      icell_latch = '0;
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      // reset contents and idle pins
      for (int i = 0; i < 5; i++) begin
         for (int p = 0; p < 4; p++) begin
            rd_chk("reset", gl[i], 2'(p), 8'h00);
         end
      end
      for (int p = 0; p < 4; p++) begin
         chk("reset oe", pin_oe[p], 8'h00);
      end
      // pattern through data out, direction, drive, mode and mask, absent bits read zero
      for (int i = 0; i < 5; i++) begin
         for (int p = 0; p < 4; p++) begin
            wr(gl[i], 2'(p), 8'hA5);
         end
      end
      for (int i = 0; i < 5; i++) begin
         for (int p = 0; p < 4; p++) begin
            rd_chk("pattern", gl[i], 2'(p),
                   live(gl[i], 2'(p)) & 8'hA5);
         end
      end
      wr(4'h9, 2'h0, 8'hFF);
      rd_chk("unmapped", 4'h9, 2'h0, 8'h00);
      rd_chk("mode c", GRP_MODE, PIDX_C, 8'h00);
      for (int i = 0; i < 5; i++) begin
         for (int p = 0; p < 4; p++) begin
            wr(gl[i], 2'(p), 8'h00);
         end
      end
      // direction ored with the product term, enable readback
      pld_oe[0] <= 8'h30;
      wr(GRP_DIRECTION, PIDX_A, 8'h0F);
      wr(GRP_DATA_OUT, PIDX_A, 8'hA5);
      wr(GRP_DIRECTION, PIDX_D, 8'hFF);
      @(negedge ref_clk);
      chk("oe a", pin_oe[0], 8'h3F);
      chk("out a", pin_out[0] & pin_oe[0], 8'h25);
      chk("oe d", pin_oe[3], 8'h07);
      rd_chk("enout a", GRP_ENOUT, PIDX_A, 8'h3F);
      // open drain high nibble and fast slew low nibble
      wr(GRP_DIRECTION, PIDX_A, 8'hFF);
      wr(GRP_DRIVE, PIDX_A, 8'hFF);
      wr(GRP_DIRECTION, PIDX_C, 8'hFF);
      wr(GRP_DATA_OUT, PIDX_C, 8'h3C);
      wr(GRP_DRIVE, PIDX_C, 8'hFF);
      wr(GRP_DRIVE, PIDX_D, 8'hFF);
      @(negedge ref_clk);
      chk("od a", pin_oe[0], 8'h5F);
      chk("slew a", fast_slew[0], 8'h0F);
      chk("od c", pin_oe[2], 8'hC3);
      chk("slew c", fast_slew[2], 8'h00);
      chk("slew d", fast_slew[3], 8'h07);
      // released open-drain bits go to the pull-up, so the level follows
      chk("pin a", pin_in[0], 8'hA5);
      // address out on A, mixed modes on B
      addr_out <= {8'h5A, 8'h3C};
      wr(GRP_DRIVE, PIDX_A, 8'h00);
      wr(GRP_MODE, PIDX_A, 8'hFF);
      wr(GRP_MODE, PIDX_B, 8'h0F);
      wr(GRP_DATA_OUT, PIDX_B, 8'hC3);
      wr(GRP_DIRECTION, PIDX_B, 8'hFF);
      @(negedge ref_clk);
      chk("addr a", pin_out[0], 8'h3C);
      chk("mixed b", pin_out[1], 8'hCA);
      // inputs: pins read back, data out keeps the stored value
      pld_oe[0] <= 8'h00;
      wr(GRP_MODE, PIDX_A, 8'h00);
      wr(GRP_DIRECTION, PIDX_A, 8'h00);
      wr(GRP_DIRECTION, PIDX_D, 8'h00);
      ext[0] <= 8'h96;
      ext[3] <= 8'hFA;
      repeat (10) @(posedge ref_clk);
      rd_chk("din a", GRP_DATA_IN, PIDX_A, 8'h96);
      rd_chk("din d", GRP_DATA_IN, PIDX_D, 8'h02);
      rd_chk("din c", GRP_DATA_IN, PIDX_C, 8'h3C);
      rd_chk("dout a", GRP_DATA_OUT, PIDX_A, 8'hA5);
      // input cell latch
      @(posedge ref_clk);
      icell_latch <= 3'h1;
      @(posedge ref_clk);
      icell_latch <= 3'h0;
      rd_chk("icell a", GRP_ICELL, PIDX_A, 8'h96);
      chk("icell q", icell_q[0], 8'h96);
      // output cells, mask blocks MCU loads
      wr(GRP_OCELL, PIDX_A, 8'hC3);
      rd_chk("ocell a", GRP_OCELL, PIDX_A, 8'hC3);
      wr(GRP_OMASK, PIDX_A, 8'h0F);
      wr(GRP_OCELL, PIDX_A, 8'h3C);
      rd_chk("masked", GRP_OCELL, PIDX_A, 8'h33);
      chk("ocell q", ocell_q[0], 8'h33);
      cell_d[1] <= 8'h5A;
      @(posedge ref_clk);
      cell_load <= 3'h2;
      @(posedge ref_clk);
      cell_load <= 3'h0;
      rd_chk("pld load", GRP_OCELL, PIDX_B, 8'h5A);
      // second reset in mid-run clears a live configuration
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rd_chk("rst dir a", GRP_DIRECTION, PIDX_A, 8'h00);
      rd_chk("rst mode b", GRP_MODE, PIDX_B, 8'h00);
      rd_chk("rst drive c", GRP_DRIVE, PIDX_C, 8'h00);
      rd_chk("rst mask a", GRP_OMASK, PIDX_A, 8'h00);
      chk("rst oe b", pin_oe[1], 8'h00);
      wrap_up();
   end
endmodule : tb_port_config_data_regs
